/* File: hdl/isp_port.sv */
// Purpose: two-wire slave port into a byte-wide register space
// Assumes: rd_data_i is combinational from rd_addr_o on sys_clk_i
// Notes:   ce_i freezes the system-clock side only; the link sampler
//          follows the serial clock
//
// Contract
// R1: slave only; clock is an input; data line driven open-drain only.
// R2: works at standard and fast serial clock rates.
// R3: master starts a transfer only while both lines are high.
// R4: data stable while clock high; changes then are control conditions.
// R5: start is data falling with clock high; stop is data rising.
// R6: one clock pulse per bit; transmitter changes data while clock low.
// R7: whole bytes, each acknowledged; byte count chosen by the master.
// R8: ninth pulse for ack; acknowledger holds data low through its high.
// R9: after master not-acknowledge the device releases the data line.
// R10: every byte travels most significant bit first.
// R11: first byte is fixed address plus direction; matching address acked.
// R12: in a write the second byte loads the pointer and is acked.
// R13: further write bytes stored at pointer, acked, pointer advances.
// R14: stop or repeated start ends a transfer; new address follows at once.
// R15: reads start at the current pointer, which advances per byte.
// R16: master acks every read byte but the last, which it does not ack.
// R17: master makes all clock pulses, starts and stops.
// R18: on address mismatch stay released and ignore all until a start.
// R19: pointer is eight bits and wraps to zero.
`timescale 1ns/1ps
module isp_port (
  input  wire logic       sys_clk_i,  // system clock, 100 MHz
  input  wire logic       rst_b_i,    // async reset, active low
  input  wire logic       ce_i,       // clock enable, freezes core
  input  wire logic       scl_i,      // serial clock pin
  input  wire logic       sda_i,      // data pin, input side
  output logic            sda_o,      // data pin, output value (low)
  output logic            sda_oe_o,   // data pin, pull low when high
  output logic            wr_en_o,    // one-cycle register write strobe
  output logic      [7:0] wr_addr_o,  // register write address
  output logic      [7:0] wr_data_o,  // register write data
  output logic      [7:0] rd_addr_o,  // register read address
  input  wire logic [7:0] rd_data_i   // register read data
);
  import isp_pkg::*;

  isp_core_t  r_reg;
  isp_core_t  r_next;
  isp_link_if lk ();
  logic [2:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic       tgl_s;
  logic       start_ev;
  logic       stop_ev;
  logic       fall_ev;
  logic       rise_ev;
  logic       active;

  // the serial clock itself clocks the bit sampler
  isp_link u_link (
    .scl_clk_i (scl_i),
    .rst_b_i   (rst_b_i),
    .sda_i     (sda_i),
    .lk        (lk.link)
  );

  // pins and the bit toggle cross together; data rides on the toggle;
  // three cycles of delay are small against a fast-mode clock phase
  isp_sync #(.W(3)) u_sync ( // R2
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    // toggle goes in inverted so the all-ones reset matches its idle value
    .d_i       ({~lk.tgl, scl_i, sda_i}),
    .q_o       (sync_q)
  );

  assign tgl_s = sync_q[2];
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // data edges while clock high are control, never data
  assign start_ev = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s; // R5 R4
  assign stop_ev  = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s; // R5 R4
  assign fall_ev  = r_reg.scl_d & ~scl_s;
  // bit value is stable for the whole clock period after the toggle
  assign rise_ev  = tgl_s ^ r_reg.tgl_d;
  assign active   = (r_reg.st != ISP_ST_IDLE) && (r_reg.st != ISP_ST_IGN);

  always_comb
  begin
    r_next       = r_reg;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    r_next.tgl_d = tgl_s;
    r_next.wr_en = 1'b0;
    r_next.drv   = 1'b0;                                        // R1
    if (start_ev)
    begin
      // a repeated start lands here too, mid-byte or not
      r_next.st   = ISP_ST_ADDR;                                // R14
      r_next.cnt  = ISP_CNT_RST;
      r_next.oe   = 1'b0;
      r_next.sent = 1'b0;
    end
    else if (stop_ev)
    begin
      r_next.st = ISP_ST_IDLE;                                  // R14
      r_next.oe = 1'b0;
    end
    else
    begin
      if (rise_ev && active)
      begin
        if (r_reg.cnt == ISP_ACK_SLOT)
        begin
          r_next.cnt  = ISP_CNT_RST;                            // R7
          r_next.sent = 1'b0;
          if (r_reg.st == ISP_ST_RDATA && r_reg.sent)
          begin
            r_next.ptr = r_reg.ptr + 8'h01;                     // R15 R19
            if (lk.bit_v)
              r_next.st = ISP_ST_IGN;                           // R9 R16
          end
        end
        else
        begin
          r_next.shr = {r_reg.shr[6:0], lk.bit_v};              // R10
          r_next.cnt = r_reg.cnt + 4'h1;
        end
      end
      if (fall_ev && active)
      begin
        if (r_reg.cnt == ISP_ACK_SLOT)
        begin
          unique case (r_reg.st)
            ISP_ST_ADDR:
            begin
              if (r_reg.shr[7:1] == ISP_SLAVE_ADDR)
              begin
                r_next.oe = 1'b1;                               // R11 R8
                r_next.st = r_reg.shr[0] ? ISP_ST_RDATA : ISP_ST_PTR;
              end
              else
              begin
                r_next.oe = 1'b0;                               // R18
                r_next.st = ISP_ST_IGN;
              end
            end
            ISP_ST_PTR:
            begin
              r_next.ptr = r_reg.shr;                           // R12
              r_next.oe  = 1'b1;
              r_next.st  = ISP_ST_WDATA;
            end
            ISP_ST_WDATA:
            begin
              r_next.wr_en   = 1'b1;                            // R13
              r_next.wr_addr = r_reg.ptr;
              r_next.wr_data = r_reg.shr;
              r_next.ptr     = r_reg.ptr + 8'h01;               // R19
              r_next.oe      = 1'b1;
            end
            ISP_ST_RDATA:
              r_next.oe = 1'b0;   // master owns the ack slot
            default:
              r_next.oe = 1'b0;
          endcase
        end
        else if (r_reg.st == ISP_ST_RDATA)
        begin
          if (r_reg.cnt == ISP_CNT_RST)
          begin
            // latch late so a write just before the read is seen
            r_next.tx   = rd_data_i;                            // R15
            r_next.oe   = ~rd_data_i[ISP_BIT_MSB];              // R10 R6
            r_next.sent = 1'b1;
          end
          else
            r_next.oe = ~r_reg.tx[ISP_BIT_MSB - r_reg.cnt[2:0]]; // R10
        end
        else
          r_next.oe = 1'b0;                                     // R8
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      r_reg <= ISP_CORE_RST;
    else if (ce_i)
      r_reg <= r_next;
  end

  assign sda_o     = r_reg.drv;
  assign sda_oe_o  = r_reg.oe;
  assign wr_en_o   = r_reg.wr_en;
  assign wr_addr_o = r_reg.wr_addr;
  assign wr_data_o = r_reg.wr_data;
  assign rd_addr_o = r_reg.ptr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pin_low_only: assert property ( // R1
    sda_o == 1'b0)
    else $error("data pin output value is not low");

  a_start_to_addr: assert property ( // R5
    ce_i && start_ev |=> r_reg.st == ISP_ST_ADDR && r_reg.cnt == 4'h0
      && !sda_oe_o)
    else $error("start did not open an address byte");

  a_stop_to_idle: assert property ( // R14
    ce_i && stop_ev && !start_ev |=> r_reg.st == ISP_ST_IDLE && !sda_oe_o)
    else $error("stop did not free the port");

  a_addr_ack: assert property ( // R11
    ce_i && fall_ev && r_reg.st == ISP_ST_ADDR && r_reg.cnt == 4'h8
      && r_reg.shr[7:1] == 7'h68 && !start_ev && !stop_ev
    |=> sda_oe_o && (r_reg.st == ISP_ST_RDATA || r_reg.st == ISP_ST_PTR))
    else $error("matching address not acknowledged");

  a_addr_miss: assert property ( // R18
    r_reg.st == ISP_ST_IGN && !start_ev |=> !$rose(sda_oe_o))
    else $error("data line driven while ignoring the bus");

  a_ptr_load: assert property ( // R12
    ce_i && fall_ev && r_reg.st == ISP_ST_PTR && r_reg.cnt == 4'h8
      && !start_ev && !stop_ev
    |=> r_reg.ptr == $past(r_reg.shr) && sda_oe_o
      && r_reg.st == ISP_ST_WDATA)
    else $error("pointer byte not loaded");

  a_write_store: assert property ( // R13
    ce_i && fall_ev && r_reg.st == ISP_ST_WDATA && r_reg.cnt == 4'h8
      && !start_ev && !stop_ev
    |=> wr_en_o && wr_data_o == $past(r_reg.shr)
      && wr_addr_o == $past(r_reg.ptr) && rd_addr_o == wr_addr_o + 8'h01
      ##1 !wr_en_o)
    else $error("write byte not stored or pointer not advanced");

  a_read_msb: assert property ( // R15
    ce_i && fall_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h0
      && !start_ev && !stop_ev
    |=> sda_oe_o == !$past(rd_data_i[7]) && r_reg.tx == $past(rd_data_i))
    else $error("read byte does not open with its top bit");

  a_nack_release: assert property ( // R9
    ce_i && rise_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h8
      && r_reg.sent && lk.bit_v && !start_ev && !stop_ev
    |=> r_reg.st == ISP_ST_IGN && !sda_oe_o)
    else $error("line not released after not-acknowledge");

  a_drive_on_low: assert property ( // R6
    $rose(sda_oe_o) |-> !scl_s)
    else $error("data line taken while clock high");

  a_hold_high: assert property ( // R4
    ce_i && scl_s && !start_ev && !stop_ev |=> $stable(sda_oe_o))
    else $error("data line moved while clock high");

  a_idle_free: assert property ( // R1
    r_reg.st == ISP_ST_IDLE |-> !sda_oe_o)
    else $error("data line held while the port is idle");

  a_strobe_single: assert property ( // R13
    ce_i && wr_en_o |=> !wr_en_o)
    else $error("write strobe longer than one cycle");

  a_ptr_wrap: assert property ( // R19
    ce_i && fall_ev && r_reg.st == ISP_ST_WDATA && r_reg.cnt == 4'h8
      && r_reg.ptr == 8'hFF && !start_ev && !stop_ev
    |=> rd_addr_o == 8'h00)
    else $error("pointer did not wrap to zero");

  a_read_advance: assert property ( // R15
    ce_i && rise_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h8
      && r_reg.sent && !start_ev && !stop_ev
    |=> rd_addr_o == $past(rd_addr_o) + 8'h01)
    else $error("pointer did not advance after a read byte");

  a_read_go_on: assert property ( // R7
    ce_i && rise_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h8
      && r_reg.sent && !lk.bit_v && !start_ev && !stop_ev
    |=> r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h0)
    else $error("acknowledged read did not continue");

  a_slot_release: assert property ( // R9
    ce_i && fall_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt == 4'h8
      && !start_ev && !stop_ev
    |=> !sda_oe_o)
    else $error("line not released for the master acknowledge");

  a_ack_end: assert property ( // R8
    ce_i && fall_ev && r_reg.cnt == 4'h0 && r_reg.st != ISP_ST_RDATA
      && !start_ev && !stop_ev
    |=> !sda_oe_o)
    else $error("acknowledge held past its clock pulse");

  a_bit_shift: assert property ( // R10
    ce_i && rise_ev && active && r_reg.cnt != 4'h8 && !start_ev && !stop_ev
    |=> r_reg.shr == {$past(r_reg.shr[6:0]), $past(lk.bit_v)}
      && r_reg.cnt == $past(r_reg.cnt) + 4'h1)
    else $error("received bit not shifted in at the bottom");

  a_read_bits: assert property ( // R6
    ce_i && fall_ev && r_reg.st == ISP_ST_RDATA && r_reg.cnt != 4'h0
      && r_reg.cnt != 4'h8 && !start_ev && !stop_ev
    |=> sda_oe_o == !$past(r_reg.tx[3'h7 - r_reg.cnt[2:0]]))
    else $error("read bit not driven in order");

  a_ign_quiet: assert property ( // R18
    ce_i && r_reg.st == ISP_ST_IGN && !start_ev && !stop_ev
    |=> r_reg.st == ISP_ST_IGN && !wr_en_o && $stable(rd_addr_o))
    else $error("ignored traffic changed the port");
endmodule : isp_port

/* File: hdl/isp_pkg.sv */
// Purpose: shared constants and types of the two-wire slave register port
// Assumes: system clock far faster than the serial clock (400 kHz max)
// Notes:   state structs of the core and link live here with their reset values; isp_sync keeps its own
package isp_pkg;

  localparam logic [6:0] ISP_SLAVE_ADDR = 7'h68;   // 1101000
  localparam logic [3:0] ISP_ACK_SLOT   = 4'h8;    // rises before ack bit
  localparam logic [7:0] ISP_PTR_RST    = 8'h00;
  localparam logic [7:0] ISP_BYTE_RST   = 8'h00;
  localparam logic [3:0] ISP_CNT_RST    = 4'h0;
  localparam logic [2:0] ISP_BIT_MSB    = 3'h7;

  // system clock period, and slowest and fastest serial clock periods the port is built for
  localparam int ISP_SYS_PERIOD_NS  = 10;
  localparam int ISP_STD_PERIOD_NS  = 10000;
  localparam int ISP_FAST_PERIOD_NS = 2500;
  localparam int ISP_FAST_PERIOD_CYC = ISP_FAST_PERIOD_NS / ISP_SYS_PERIOD_NS;

  typedef enum logic [2:0] {
    ISP_ST_IDLE  = 3'b000,
    ISP_ST_ADDR  = 3'b001,
    ISP_ST_PTR   = 3'b010,
    ISP_ST_WDATA = 3'b011,
    ISP_ST_RDATA = 3'b100,
    ISP_ST_IGN   = 3'b101
  } isp_state_t;

  typedef struct packed {
    isp_state_t  st;
    logic [3:0]  cnt;
    logic [7:0]  shr;
    logic [7:0]  tx;
    logic [7:0]  ptr;
    logic        scl_d;
    logic        sda_d;
    logic        tgl_d;
    logic        oe;
    logic        sent;
    logic        drv;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } isp_core_t;

  localparam isp_core_t ISP_CORE_RST = '{
    st: ISP_ST_IDLE, cnt: ISP_CNT_RST, shr: ISP_BYTE_RST, tx: ISP_BYTE_RST,
    ptr: ISP_PTR_RST, scl_d: 1'b1, sda_d: 1'b1, tgl_d: 1'b1, oe: 1'b0,
    sent: 1'b0, drv: 1'b0, wr_en: 1'b0, wr_addr: ISP_BYTE_RST,
    wr_data: ISP_BYTE_RST};

  typedef struct packed {
    logic bit_v;
    logic tgl;
  } isp_link_t;

  localparam isp_link_t ISP_LINK_RST = '{bit_v: 1'b0, tgl: 1'b0};

endpackage : isp_pkg

/* File: hdl/isp_link_if.sv */
// Purpose: carries each sampled serial bit from the link side to the core
// Assumes: bit_v is stable whenever tgl is seen to change
// Notes:   bundled data; only tgl is synchronised
`timescale 1ns/1ps
interface isp_link_if;
  logic bit_v;
  logic tgl;
  modport link (output bit_v, output tgl);
  modport core (input bit_v, input tgl);
endinterface : isp_link_if

/* File: hdl/isp_sync.sv */
// Purpose: two-flop synchroniser for pins and crossing toggles
// Assumes: inputs are asynchronous to sys_clk_i
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module isp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i, // system clock
  input  wire logic         rst_b_i,   // async reset, active low
  input  wire logic         ce_i,      // clock enable
  input  wire logic [W-1:0] d_i,       // asynchronous input
  output logic      [W-1:0] q_o        // synchronised output
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } isp_sync_t;

  isp_sync_t r_reg;
  isp_sync_t r_next;

  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  // idle bus is high, so reset to ones avoids a false start at release
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      r_reg <= '1;
    else if (ce_i)
      r_reg <= r_next;
  end

  assign q_o = r_reg.s2;
endmodule : isp_sync

/* File: hdl/isp_link.sv */
// Purpose: samples the data line on each rising serial clock edge
// Assumes: the master owns the serial clock; it may stop between frames
// Notes:   nothing here depends on edges outside a bit pulse
`timescale 1ns/1ps
module isp_link (
  input  wire logic scl_clk_i, // serial clock from the master
  input  wire logic rst_b_i,   // async reset, active low
  input  wire logic sda_i,     // data line level
  isp_link_if.link  lk         // sampled bit to the core
);
  import isp_pkg::*;

  isp_link_t r_reg;
  isp_link_t r_next;

  always_comb
  begin
    r_next       = r_reg;
    r_next.bit_v = sda_i;      // R6
    r_next.tgl   = ~r_reg.tgl;
  end

  always_ff @(posedge scl_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      r_reg <= ISP_LINK_RST;
    else
      r_reg <= r_next;
  end

  assign lk.bit_v = r_reg.bit_v;
  assign lk.tgl   = r_reg.tgl;
endmodule : isp_link

/* File: tb/isp_master_bfm.sv */
// Purpose: two-wire bus master model that drives the port
// Assumes: the line has a pull-up; sda_o high means released
// Notes:   the clock stands high between frames, 2.5 us per bit
//          unless the bench sets a slower quarter period
`timescale 1ns/1ps
module isp_master_bfm (
  output logic      scl_o, // serial clock
  output logic      sda_o, // data drive, 1 = release
  input  wire logic sda_i  // resolved data line
);
  int qtr_ns = 625; // quarter of a bit period in ns

  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // also serves as a repeated start from a low clock
  task automatic start();
    sda_o = 1'b1;
    #(qtr_ns) scl_o = 1'b1;
    #(qtr_ns) sda_o = 1'b0;
    #(qtr_ns) scl_o = 1'b0;
    #(qtr_ns);
  endtask : start

  // sampled twice while high; a change there shows up as unknown
  task automatic bit_io(input logic b, output logic s);
    logic s1;
    sda_o = b;
    #(qtr_ns) scl_o = 1'b1;
    #(qtr_ns) s1 = sda_i;
    #(qtr_ns - 1) s = (s1 === sda_i) ? s1 : 1'bx;
    #1 scl_o = 1'b0;
    #(qtr_ns);
  endtask : bit_io

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : write_byte

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask : read_byte

  task automatic stop();
    sda_o = 1'b0;
    #(qtr_ns) scl_o = 1'b1;
    #(qtr_ns) sda_o = 1'b1;
    #(qtr_ns);
  endtask : stop
endmodule : isp_master_bfm

/* File: tb/i2c_slave_register_port_tb_top.sv */
// Purpose: self-checking bench for the register port
// Assumes: register space is a plain byte array read combinationally
// Notes:   the clock enable stays high; stalls are not exercised
`timescale 1ns/1ps
module i2c_slave_register_port_tb_top;
  import isp_pkg::*;
  logic        sys_clk_i;
  logic        rst_b_i;
  logic        ce_i;
  logic        scl;
  logic        m_sda;
  wire logic   sda;
  logic        sda_o;
  logic        sda_oe_o;
  logic        wr_en_o;
  logic [7:0]  wr_addr_o;
  logic [7:0]  wr_data_o;
  logic [7:0]  rd_addr_o;
  logic [7:0]  regs [256];
  logic [15:0] strb [$];
  int          compares;
  int          miscompares;
  int          cycles;
  localparam logic [7:0] DAT [3] = '{8'hA5, 8'h3C, 8'h81};

  assign sda = m_sda & (~sda_oe_o | sda_o);

  isp_master_bfm u_mst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));

  isp_port u_dut (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .scl_i     (scl),
    .sda_i     (sda),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .wr_en_o   (wr_en_o),
    .wr_addr_o (wr_addr_o),
    .wr_data_o (wr_data_o),
    .rd_addr_o (rd_addr_o),
    .rd_data_i (regs[rd_addr_o])
  );

  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (wr_en_o === 1'b1)
    begin
      regs[wr_addr_o] <= wr_data_o;
      strb.push_back({wr_addr_o, wr_data_o});
    end
    if (cycles == 90000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %b got %b", what, exp, got);
    end
  endtask : check_bit

  // the pointer runs past the top of the space mid-burst
  task automatic test_write_wrap();
    logic       a;
    logic [7:0] p;
    strb.delete();
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b0}, a);
    check_bit("addr_ack", 1'b1, a);
    u_mst.write_byte(8'hFE, a);
    check_bit("ptr_ack", 1'b1, a);
    for (int i = 0; i < 3; i++)
    begin
      u_mst.write_byte(DAT[i], a);
      check_bit("data_ack", 1'b1, a);
    end
    u_mst.stop();
    check_byte("strobes", 8'h03, 8'(strb.size()));
    p = 8'hFE;
    for (int i = 0; i < strb.size(); i++)
    begin
      check_byte("wr_addr", p, strb[i][15:8]);
      check_byte("wr_data", DAT[i], strb[i][7:0]);
      p++;
    end
    check_byte("pointer", 8'h01, rd_addr_o);
    $display("test_write_wrap done");
  endtask : test_write_wrap

  // pointer set, repeated start, read with nack, then a bare read
  task automatic test_read_back();
    logic       a;
    logic [7:0] d;
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b0}, a);
    u_mst.write_byte(8'hFE, a);
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b1}, a);
    check_bit("rd_addr_ack", 1'b1, a);
    u_mst.read_byte(1'b1, d);
    check_byte("rd_first", DAT[0], d);
    u_mst.read_byte(1'b0, d);
    check_byte("rd_last", DAT[1], d);
    check_bit("released", 1'b0, sda_oe_o);
    u_mst.stop();
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b1}, a);
    u_mst.read_byte(1'b0, d);
    check_byte("rd_reuse", DAT[2], d);
    u_mst.stop();
    check_byte("pointer", 8'h01, rd_addr_o);
    $display("test_read_back done");
  endtask : test_read_back

  // a foreign address is ignored until the next start
  task automatic test_bad_addr();
    logic a;
    strb.delete();
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
    check_bit("bad_ack", 1'b0, a);
    u_mst.write_byte(8'h20, a);
    check_bit("ign_ack", 1'b0, a);
    u_mst.stop();
    check_byte("strobes", 8'h00, 8'(strb.size()));
    check_byte("pointer", 8'h01, rd_addr_o);
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b0}, a);
    check_bit("again_ack", 1'b1, a);
    u_mst.stop();
    $display("test_bad_addr done");
  endtask : test_bad_addr

  // one write at the standard rate, read back at the fast rate
  task automatic test_std_rate();
    logic       a;
    logic [7:0] d;
    strb.delete();
    u_mst.qtr_ns = ISP_STD_PERIOD_NS / 4;
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b0}, a);
    check_bit("std_addr_ack", 1'b1, a);
    u_mst.write_byte(8'h10, a);
    check_bit("std_ptr_ack", 1'b1, a);
    u_mst.write_byte(8'h5A, a);
    check_bit("std_data_ack", 1'b1, a);
    check_bit("pin_low", 1'b0, sda_o);
    u_mst.stop();
    u_mst.qtr_ns = ISP_FAST_PERIOD_NS / 4;
    check_byte("std_strobes", 8'h01, 8'(strb.size()));
    check_byte("std_wr_addr", 8'h10, strb[0][15:8]);
    check_byte("std_wr_data", 8'h5A, strb[0][7:0]);
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b0}, a);
    u_mst.write_byte(8'h10, a);
    u_mst.start();
    u_mst.write_byte({ISP_SLAVE_ADDR, 1'b1}, a);
    u_mst.read_byte(1'b0, d);
    u_mst.stop();
    check_byte("std_read", 8'h5A, d);
    check_byte("pointer", 8'h11, rd_addr_o);
    $display("test_std_rate done");
  endtask : test_std_rate

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    check_byte("ptr_reset", ISP_PTR_RST, rd_addr_o);
    test_write_wrap();
    test_read_back();
    test_bad_addr();
    test_std_rate();
    print_verdict();
  end
endmodule : i2c_slave_register_port_tb_top
